// File: core/stpd_defs.svh
// Timing, register map and field constants of the powerdown controller
`ifndef STPD_DEFS_SVH
`define STPD_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define STPD_CLK_MHZ      125
`define STPD_TICK_US      1
`define STPD_TICK_CYC     (`STPD_TICK_US * `STPD_CLK_MHZ)
`define STPD_INACT_S      30
`define STPD_INACT_TICKS  (`STPD_INACT_S * 1000000 / `STPD_TICK_US)
`define STPD_INVALID_US   30
`define STPD_INVALID_CYC  (`STPD_INVALID_US * `STPD_CLK_MHZ)
`define STPD_VALID_US     1
`define STPD_VALID_CYC    (`STPD_VALID_US * `STPD_CLK_MHZ)
`define STPD_WAKE_US      100
`define STPD_WAKE_CYC     (`STPD_WAKE_US * `STPD_CLK_MHZ)

// ----------------------------------------------------------------------
// Register map (word index = byte address bits 3:2)
// ----------------------------------------------------------------------
`define STPD_IDX_STATUS   2'h0
`define STPD_IDX_CTRL     2'h1
`define STPD_IDX_IRQ_STAT 2'h2
`define STPD_IDX_IRQ_MASK 2'h3
`define STPD_CTRL_EMUL    0
`define STPD_CTRL_SWDN    1
`define STPD_CTRL_W       2
`define STPD_EV_DOWN      0
`define STPD_EV_READY     1
`define STPD_EV_INV_FALL  2
`define STPD_EV_INV_RISE  3
`define STPD_EV_LATE      4
`define STPD_EV_W         5
`define STPD_RESP_OKAY    2'h0
`define STPD_RESP_SLVERR  2'h2

`endif

// File: core/stpd_pkg.sv
// Types shared by the powerdown controller
package stpd_pkg;
    typedef enum logic [1:0] {
        STPD_PD   = 2'h0,
        STPD_RAMP = 2'h1,
        STPD_UP   = 2'h3
    } stpd_pwr_e;
endpackage : stpd_pkg

// File: core/stpd_ctrl.sv
// Serial transceiver powerdown controller with AXI4-Lite register slave
// How it works
// - Low force-down input powers the device down, overriding force-active.
// - Automatic timer acts only with force-active low and force-down high.
// - Thirty seconds without line transitions powers down pump and transmitters.
// - Any line transition powers the device back up after automatic powerdown.
// - Manual powerdown with auto enabled holds until both high or transition.
// - Entering powerdown with force-active low leaves the inactivity timer expired until released.
// - Falling force-active restarts the timer, giving thirty seconds powered up.
// - Standard receiver outputs are disabled during forced powerdown, not timer powerdown, on the wake variant.
// - Leaving powerdown until transmit-ready takes at most one hundred microseconds.
// - Invalid flag falls after invalid levels persist over thirty microseconds.
// - Invalid flag rises one microsecond after a valid level appears.
// - Invalid flag never changes power state unless routed to force inputs.
// - Invalid detection runs in every power mode.
// - Ready output falls on powerdown, rises once negative rail is reached or the wake-up time runs out.
`include "stpd_defs.svh"

module stpd_ctrl #(
    parameter int          N_TX        = 3,
    parameter int          N_RX        = 5,
    parameter int          ADDR_W      = 8,
    parameter int unsigned INACT_TICKS = `STPD_INACT_TICKS,
    parameter int unsigned WAKE_CYC    = `STPD_WAKE_CYC,
    parameter bit          HAS_WAKE_RX = 1'b1
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              force_active_input_i,
    input  wire logic              force_down_input_i,
    input  wire logic [N_TX-1:0]   tx_in_i,
    input  wire logic [N_RX-1:0]   rx_in_i,
    input  wire logic [N_RX-1:0]   rx_level_ok_i,
    input  wire logic              pump_rail_ok_i,
    output logic                   pump_en_o,
    output logic                   tx_en_o,
    output logic                   ready_o,
    output logic                   rx_std_en_o,
    output logic                   invalid_n_o,
    output logic                   irq_o,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    localparam int NL       = N_TX + N_RX;
    localparam int NP       = NL + N_RX + 3;
    localparam int TICK_CYC = `STPD_TICK_CYC;
    localparam int TW       = $clog2(TICK_CYC);
    localparam int IW       = $clog2(INACT_TICKS + 1);
    localparam int WW       = $clog2(WAKE_CYC + 1);
    localparam int VW       = $clog2(`STPD_INVALID_CYC + 1);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [NP-1:0] pin_s1;
    logic [NP-1:0] pin_s2;
    logic [NP-1:0] pin_s3;
    logic [NP-1:0] pin_diff;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= {pump_rail_ok_i, force_down_input_i, force_active_input_i,
                       rx_level_ok_i, rx_in_i, tx_in_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Only the second stage and later are read
    assign pin_diff = pin_s2 ^ pin_s3;

    logic [N_RX-1:0] rxv_s;
    logic            fon_s;
    logic            foff_s;
    logic            pump_s;
    logic            line_edge;

    assign rxv_s     = pin_s2[NL +: N_RX];
    assign fon_s     = pin_s2[NP-3];
    assign foff_s    = pin_s2[NP-2];
    assign pump_s    = pin_s2[NP-1];
    assign line_edge = |pin_diff[NL-1:0];

    // ------------------------------------------------------------------
    // Microsecond tick
    // ------------------------------------------------------------------
    logic [TW-1:0] tick_cnt;
    logic [TW-1:0] next_tick_cnt;
    logic          tick;

    always_comb begin
        tick          = (tick_cnt == TW'(TICK_CYC - 1));
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) tick_cnt <= '0;
        else          tick_cnt <= next_tick_cnt;
    end

    // ------------------------------------------------------------------
    // Effective force inputs
    // ------------------------------------------------------------------
    logic [`STPD_CTRL_W-1:0] ctrl;
    logic                    inv_n;
    logic                    fon_eff;
    logic                    foff_eff;
    logic                    fon_q;
    logic                    fon_edge;

    // Internal feedback saves the board wiring; software picks it
    assign fon_eff  = ctrl[`STPD_CTRL_EMUL] ? inv_n : fon_s;
    assign foff_eff = (ctrl[`STPD_CTRL_EMUL] ? inv_n : foff_s)
                      & ~ctrl[`STPD_CTRL_SWDN];
    assign fon_edge = fon_eff ^ fon_q;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) fon_q <= 1'b0;
        else          fon_q <= fon_eff;
    end

    // ------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------
    stpd_pkg::stpd_pwr_e state;
    stpd_pkg::stpd_pwr_e next_state;
    logic [WW-1:0]       wake_cnt;
    logic [WW-1:0]       next_wake_cnt;
    logic                rx_std_en;
    logic                next_rx_std_en;
    logic                expired;
    logic                down_req;
    logic                down_entry;
    logic                wake_late;

    always_comb begin
        down_req       = !foff_eff || (!fon_eff && expired);
        next_state     = state;
        next_wake_cnt  = wake_cnt;
        wake_late      = 1'b0;
        next_rx_std_en = !(HAS_WAKE_RX && !foff_eff);
        unique case (state)
            stpd_pkg::STPD_PD: begin
                next_wake_cnt = '0;
                if (!down_req) next_state = stpd_pkg::STPD_RAMP;
            end
            stpd_pkg::STPD_RAMP: begin
                if (down_req) begin
                    next_state = stpd_pkg::STPD_PD;
                end else if (pump_s) begin
                    next_state = stpd_pkg::STPD_UP;
                end else if (wake_cnt == WW'(WAKE_CYC - 2)) begin
                    // Slow rail: transmit anyway and flag it
                    next_state = stpd_pkg::STPD_UP;
                    wake_late  = 1'b1;
                end else begin
                    next_wake_cnt = wake_cnt + 1'b1;
                end
            end
            stpd_pkg::STPD_UP: begin
                if (down_req) next_state = stpd_pkg::STPD_PD;
            end
            default: next_state = stpd_pkg::STPD_PD;
        endcase
        down_entry = (state != stpd_pkg::STPD_PD) && (next_state == stpd_pkg::STPD_PD);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state     <= stpd_pkg::STPD_PD;
            wake_cnt  <= '0;
            rx_std_en <= 1'b0;
        end else begin
            state     <= next_state;
            wake_cnt  <= next_wake_cnt;
            rx_std_en <= next_rx_std_en;
        end
    end

    assign pump_en_o   = state[0];
    assign tx_en_o     = state[1];
    assign ready_o     = state[1];
    assign rx_std_en_o = rx_std_en;

    // ------------------------------------------------------------------
    // Inactivity timer
    // ------------------------------------------------------------------
    logic [IW-1:0] inact_cnt;
    logic [IW-1:0] next_inact_cnt;
    logic          next_expired;

    always_comb begin
        next_inact_cnt = inact_cnt;
        next_expired   = expired;
        if (line_edge || fon_eff) begin
            next_inact_cnt = '0;
            next_expired   = 1'b0;
        end else if (down_entry) begin
            // Tied force inputs fall together: entry must still leave it expired
            next_expired = 1'b1;
        end else if (fon_edge) begin
            next_inact_cnt = '0;
            next_expired   = 1'b0;
        end else if (tick && !expired) begin
            if (inact_cnt == IW'(INACT_TICKS - 1)) next_expired = 1'b1;
            else next_inact_cnt = inact_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            inact_cnt <= '0;
            expired   <= 1'b0;
        end else begin
            inact_cnt <= next_inact_cnt;
            expired   <= next_expired;
        end
    end

    // ------------------------------------------------------------------
    // Invalid-level flag, independent of power state
    // ------------------------------------------------------------------
    logic [VW-1:0] inv_cnt;
    logic [VW-1:0] next_inv_cnt;
    logic          next_inv_n;
    logic          all_invalid;

    always_comb begin
        all_invalid  = ~|rxv_s;
        next_inv_cnt = '0;
        next_inv_n   = inv_n;
        if (inv_n && all_invalid) begin
            if (inv_cnt == VW'(`STPD_INVALID_CYC)) next_inv_n = 1'b0;
            else next_inv_cnt = inv_cnt + 1'b1;
        end else if (!inv_n && !all_invalid) begin
            if (inv_cnt == VW'(`STPD_VALID_CYC - 1)) next_inv_n = 1'b1;
            else next_inv_cnt = inv_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            inv_cnt <= '0;
            inv_n   <= 1'b1;
        end else begin
            inv_cnt <= next_inv_cnt;
            inv_n   <= next_inv_n;
        end
    end

    // Drives no power logic unless emulation is selected
    assign invalid_n_o = inv_n;

    // ------------------------------------------------------------------
    // AXI4-Lite slave and interrupts
    // ------------------------------------------------------------------
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        return (a >> 4) == '0 && a[1:0] == 2'h0;
    endfunction

    logic                    aw_hold;
    logic                    next_aw_hold;
    logic [ADDR_W-1:0]       aw_addr;
    logic [ADDR_W-1:0]       next_aw_addr;
    logic                    w_hold;
    logic                    next_w_hold;
    logic [31:0]             w_data;
    logic [31:0]             next_w_data;
    logic [3:0]              w_strb;
    logic [3:0]              next_w_strb;
    logic                    bvalid;
    logic                    next_bvalid;
    logic [1:0]              bresp;
    logic [1:0]              next_bresp;
    logic                    rvalid;
    logic                    next_rvalid;
    logic [31:0]             rdata;
    logic [31:0]             next_rdata;
    logic [1:0]              rresp;
    logic [1:0]              next_rresp;
    logic [`STPD_CTRL_W-1:0] next_ctrl;
    logic [`STPD_EV_W-1:0]   irq_stat;
    logic [`STPD_EV_W-1:0]   next_irq_stat;
    logic [`STPD_EV_W-1:0]   irq_mask;
    logic [`STPD_EV_W-1:0]   next_irq_mask;
    logic [`STPD_EV_W-1:0]   ev;
    logic [`STPD_EV_W-1:0]   w1c;
    logic                    irq;
    logic                    next_irq;
    logic                    do_wr;
    logic [31:0]             status;

    assign s_axi_awready = !aw_hold && !bvalid;
    assign s_axi_wready  = !w_hold && !bvalid;
    assign s_axi_arready = !rvalid;

    always_comb begin
        status = '0;
        status[5:0] = {foff_s, fon_s, expired, inv_n, state[1], state[0]};
        ev = '0;
        ev[`STPD_EV_DOWN]     = down_entry;
        ev[`STPD_EV_READY]    = (state != stpd_pkg::STPD_UP)
                                && (next_state == stpd_pkg::STPD_UP);
        ev[`STPD_EV_INV_FALL] = inv_n && !next_inv_n;
        ev[`STPD_EV_INV_RISE] = !inv_n && next_inv_n;
        ev[`STPD_EV_LATE]     = wake_late;
        next_aw_hold  = aw_hold;
        next_aw_addr  = aw_addr;
        next_w_hold   = w_hold;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_bvalid   = bvalid;
        next_bresp    = bresp;
        next_rvalid   = rvalid;
        next_rdata    = rdata;
        next_rresp    = rresp;
        next_ctrl     = ctrl;
        next_irq_mask = irq_mask;
        w1c           = '0;
        do_wr         = aw_hold && w_hold;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
        if (do_wr) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = reg_mapped(aw_addr) ? `STPD_RESP_OKAY : `STPD_RESP_SLVERR;
            if (reg_mapped(aw_addr) && w_strb[0]) begin
                unique case (aw_addr[3:2])
                    `STPD_IDX_CTRL:     next_ctrl     = w_data[`STPD_CTRL_W-1:0];
                    `STPD_IDX_IRQ_STAT: w1c           = w_data[`STPD_EV_W-1:0];
                    `STPD_IDX_IRQ_MASK: next_irq_mask = w_data[`STPD_EV_W-1:0];
                    `STPD_IDX_STATUS:   ;
                endcase
            end
        end
        if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = '0;
            next_rresp  = `STPD_RESP_SLVERR;
            if (reg_mapped(s_axi_araddr)) begin
                next_rresp = `STPD_RESP_OKAY;
                unique case (s_axi_araddr[3:2])
                    `STPD_IDX_STATUS:   next_rdata = status;
                    `STPD_IDX_CTRL:     next_rdata[`STPD_CTRL_W-1:0] = ctrl;
                    `STPD_IDX_IRQ_STAT: next_rdata[`STPD_EV_W-1:0] = irq_stat;
                    `STPD_IDX_IRQ_MASK: next_rdata[`STPD_EV_W-1:0] = irq_mask;
                endcase
            end
        end
        // A new event beats a simultaneous clear
        next_irq_stat = (irq_stat & ~w1c) | ev;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            aw_hold  <= 1'b0;
            aw_addr  <= '0;
            w_hold   <= 1'b0;
            w_data   <= '0;
            w_strb   <= '0;
            bvalid   <= 1'b0;
            bresp    <= `STPD_RESP_OKAY;
            rvalid   <= 1'b0;
            rdata    <= '0;
            rresp    <= `STPD_RESP_OKAY;
            ctrl     <= '0;
            irq_stat <= '0;
            irq_mask <= '0;
            irq      <= 1'b0;
        end else begin
            aw_hold  <= next_aw_hold;
            aw_addr  <= next_aw_addr;
            w_hold   <= next_w_hold;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
            ctrl     <= next_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq      <= next_irq;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata  = rdata;
    assign s_axi_rresp  = rresp;
    assign irq_o        = irq;

endmodule // stpd_ctrl

// File: sim/stpd_ctrl_checker.sv
// Port-level assertion checker for the powerdown controller
module stpd_ctrl_checker #(
    parameter int N_RX = 5
) (
    input wire logic            core_clk_i,
    input wire logic            rst_n_i,
    input wire logic            force_down_input_i,
    input wire logic [N_RX-1:0] rx_level_ok_i,
    input wire logic            pump_en_o,
    input wire logic            tx_en_o,
    input wire logic            ready_o,
    input wire logic            rx_std_en_o,
    input wire logic            invalid_n_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // Run lengths of invalid and valid receiver levels
    // ------------------------------------------------------------
    int unsigned bad_cnt;
    int unsigned good_cnt;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bad_cnt  <= 0;
            good_cnt <= 0;
        end else begin
            bad_cnt  <= (rx_level_ok_i == '0) ? bad_cnt + 1 : 0;
            good_cnt <= (rx_level_ok_i != '0) ? good_cnt + 1 : 0;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_ready_tx;
        ready_o == tx_en_o;
    endproperty
    a_ready_tx: assert property (p_ready_tx) else $error("ready differs from tx enable");
    property p_tx_pump;
        tx_en_o |-> pump_en_o;
    endproperty
    a_tx_pump: assert property (p_tx_pump) else $error("transmit without pump");
    property p_rise_pump;
        $rose(ready_o) |-> $past(pump_en_o);
    endproperty
    a_rise_pump: assert property (p_rise_pump) else $error("ready before pump ramp");
    property p_manual;
        (!force_down_input_i) [*5] |-> !pump_en_o && !ready_o;
    endproperty
    a_manual: assert property (p_manual) else $error("force-down ignored");
    property p_rx_off;
        (!force_down_input_i) [*5] |-> !rx_std_en_o;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receivers on in powerdown");
    property p_wake;
        $rose(pump_en_o) |-> ##[0:45] (ready_o || !pump_en_o);
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up too slow");
    property p_inv_fall;
        $fell(invalid_n_o) |-> bad_cnt >= 3750;
    endproperty
    a_inv_fall: assert property (p_inv_fall) else $error("invalid flag fell early");
    property p_inv_late;
        bad_cnt == 3770 |-> !invalid_n_o;
    endproperty
    a_inv_late: assert property (p_inv_late) else $error("invalid flag fell late");
    property p_inv_rise;
        $rose(invalid_n_o) |-> good_cnt >= 125;
    endproperty
    a_inv_rise: assert property (p_inv_rise) else $error("invalid flag rose early");
    property p_inv_soon;
        good_cnt == 135 |-> invalid_n_o;
    endproperty
    a_inv_soon: assert property (p_inv_soon) else $error("invalid flag rose late");
endmodule // stpd_ctrl_checker

bind stpd_ctrl stpd_ctrl_checker #(.N_RX(N_RX)) u_chk (.*);

// File: sim/stpd_host_model.sv
// Host power-management logic driving the two force inputs
module stpd_host_model (
    input  wire logic       clk_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       invalid_n_i,
    output logic            force_active_o = 1'b0,
    output logic            force_down_o   = 1'b0
);
    // Mode 0 on, 1 auto, 2 shutdown, 3 flag-driven
    always @(posedge clk_i) begin
        case (mode_i)
            2'h0: begin
                force_active_o <= 1'b1;
                force_down_o   <= 1'b1;
            end
            2'h1: begin
                force_active_o <= 1'b0;
                force_down_o   <= 1'b1;
            end
            2'h2: begin
                force_active_o <= 1'b0;
                force_down_o   <= 1'b0;
            end
            default: begin
                force_active_o <= invalid_n_i;
                force_down_o   <= invalid_n_i;
            end
        endcase
    end
endmodule // stpd_host_model

// File: sim/stpd_ctrl_tb_top.sv
// Self-checking testbench of the powerdown controller
`include "stpd_defs.svh"
module stpd_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i, rst_n_i, force_active_input_i, force_down_input_i, pump_rail_ok_i;
    logic [2:0] tx_in_i;
    logic [4:0] rx_in_i, rx_level_ok_i;
    logic pump_en_o, tx_en_o, ready_o, rx_std_en_o, invalid_n_o, irq_o, rail_on;
    logic [1:0] mode, s_axi_bresp, s_axi_rresp;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_fail = 0;
    int compares = 0;

    // Short counts keep the run brief
    stpd_ctrl #(.INACT_TICKS(20), .WAKE_CYC(40)) dut (.*);
    stpd_host_model u_host (.clk_i(core_clk_i), .mode_i(mode), .invalid_n_i(invalid_n_o),
        .force_active_o(force_active_input_i), .force_down_o(force_down_input_i));

    always #4 core_clk_i = ~core_clk_i;
    // Rail settles a cycle after the pump starts, unless held off
    always @(posedge core_clk_i) pump_rail_ok_i <= pump_en_o & rail_on;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task results;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        @(posedge core_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && k < 50);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bvalid), 32'h1);
        check(32'(s_axi_bresp), 32'(er));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        @(posedge core_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && k < 50);
        s_axi_rready <= 1'b0;
        check(32'(s_axi_rvalid), 32'h1);
        check(s_axi_rdata, ed);
        check(32'(s_axi_rresp), 32'(er));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs;
        rd(8'h04, 32'h0, `STPD_RESP_OKAY);
        wr(8'h04, 32'h3, `STPD_RESP_OKAY);
        rd(8'h04, 32'h3, `STPD_RESP_OKAY);
        wr(8'h04, 32'h0, `STPD_RESP_OKAY);
        wr(8'h10, 32'hffff_ffff, `STPD_RESP_SLVERR);
        rd(8'h10, 32'h0, `STPD_RESP_SLVERR);
    endtask
    task t_manual;
        mode <= 2'h0;
        cyc(60);
        check(32'(ready_o), 32'h1);
        check(32'(rx_std_en_o), 32'h1);
        // Old events cleared so the interrupt below comes from this entry
        wr(8'h08, 32'h1f, `STPD_RESP_OKAY);
        wr(8'h0c, 32'h1, `STPD_RESP_OKAY);
        check(32'(irq_o), 32'h0);
        mode <= 2'h2;
        cyc(10);
        check(32'(pump_en_o), 32'h0);
        check(32'(ready_o), 32'h0);
        check(32'(rx_std_en_o), 32'h0);
        check(32'(irq_o), 32'h1);
        wr(8'h08, 32'h1, `STPD_RESP_OKAY);
        cyc(2);
        check(32'(irq_o), 32'h0);
        mode <= 2'h1;
        cyc(100);
        check(32'(pump_en_o), 32'h0);
        rail_on <= 1'b0;
        tx_in_i <= ~tx_in_i;
        cyc(60);
        check(32'(ready_o), 32'h1);
        rail_on <= 1'b1;
    endtask
    task t_auto;
        mode <= 2'h0;
        cyc(50);
        mode <= 2'h1;
        cyc(2300);
        check(32'(ready_o), 32'h1);
        cyc(400);
        check(32'(pump_en_o), 32'h0);
        cyc(3000);
        check(32'(ready_o), 32'h0);
        rx_in_i <= ~rx_in_i;
        cyc(60);
        check(32'(ready_o), 32'h1);
        mode <= 2'h0;
        cyc(3000);
        check(32'(ready_o), 32'h1);
    endtask
    task t_inv;
        rx_level_ok_i <= 5'h00;
        cyc(3700);
        check(32'(invalid_n_o), 32'h1);
        cyc(100);
        check(32'(invalid_n_o), 32'h0);
        check(32'(ready_o), 32'h1);
        rx_level_ok_i <= 5'h04;
        cyc(110);
        check(32'(invalid_n_o), 32'h0);
        cyc(30);
        check(32'(invalid_n_o), 32'h1);
    endtask
    task t_emul;
        mode <= 2'h3;
        rail_on <= 1'b0;
        rx_level_ok_i <= 5'h00;
        cyc(3850);
        check(32'(pump_en_o), 32'h0);
        check(32'(invalid_n_o), 32'h0);
        rx_level_ok_i <= 5'h10;
        cyc(200);
        check(32'(invalid_n_o), 32'h1);
        check(32'(ready_o), 32'h1);
    endtask

    initial begin
        core_clk_i = 1'b0;
        rst_n_i = 1'b0;
        mode = 2'h0;
        rail_on = 1'b1;
        tx_in_i = 3'h0;
        rx_in_i = 5'h00;
        rx_level_ok_i = 5'h1f;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        cyc(16);
        rst_n_i <= 1'b1;
        t_regs;
        t_manual;
        t_auto;
        t_inv;
        t_emul;
        results;
    end
    // Whole sequence needs about 17000 cycles
    initial begin
        repeat (40000) @(posedge core_clk_i);
        n_fail++;
        results;
    end
endmodule // stpd_ctrl_tb_top
